// [acc_pkg.sv]
package acc_pkg;

  // Sample word and raw converter word
  localparam int CODE_W = 8;
  localparam int RAW_W  = 10;
  localparam logic [7:0] CODE_MIN = 8'h00;
  localparam logic [7:0] CODE_MAX = 8'hff;

  // Calibrate pin qualification, in sample clock cycles
  localparam int          CMD_CNT_W      = 4;
  localparam logic [3:0]  CMD_MIN_CYCLES = 4'ha;

  // Pipeline: stage index feeding each output bus
  localparam int PIPE_DEPTH  = 7;
  localparam int DIRECT_TAP  = 5;
  localparam int DELAYED_TAP = 6;

  // Power-up delay, in sample clock cycles
  localparam int          DLY_W           = 31;
  localparam logic [30:0] PWRUP_DLY_SHORT = 31'h0100_0000;
  localparam logic [30:0] PWRUP_DLY_LONG  = 31'h4000_0000;

  // Calibration length, in sample clock cycles
  localparam int          CAL_W      = 16;
  localparam logic [15:0] CAL_CYCLES = 16'hb3b0;

  // Cycles after wake before output words are trusted
  localparam int         FLUSH_W      = 4;
  localparam logic [3:0] FLUSH_CYCLES = 4'h8;

  // Pin synchroniser bit positions
  localparam int PIN_CAL  = 0;
  localparam int PIN_PD   = 1;
  localparam int PIN_DLY  = 2;
  localparam int PIN_FSR  = 3;
  localparam int PIN_EDGE = 4;
  localparam int PIN_W    = 5;

  typedef enum logic [1:0] {
    ST_WAIT = 2'h0,
    ST_CAL  = 2'h1,
    ST_IDLE = 2'h3
  } acc_state_t;

  // Clamp a raw word to the offset binary code range; top bit flags out of range
  function automatic logic [CODE_W:0] sat_code(input logic [RAW_W-1:0] raw);
    if (raw[RAW_W-1])
      return {1'b1, CODE_MIN};
    else if (raw[RAW_W-2])
      return {1'b1, CODE_MAX};
    else
      return {1'b0, raw[CODE_W-1:0]};
  endfunction

endpackage

// [acc_sync.sv]
module acc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Asynchronous levels in, qualified levels out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1Ff;
  logic [WIDTH-1:0] s2Ff;
  logic [WIDTH-1:0] s3Ff;
  logic [WIDTH-1:0] outFf;

  always_ff @(posedge clk)
  begin
    s1Ff <= din;
    s2Ff <= s1Ff;
    s3Ff <= s2Ff;
  end

  // Outside reset a bit moves only once the second and third stage agree; reset loads the third stage
  always_ff @(posedge clk)
  begin
    if (rst)
      outFf <= s3Ff;
    else
      outFf <= (s2Ff & s3Ff) | (outFf & (s2Ff ^ s3Ff));
  end

  assign dout = outFf;

endmodule

// [acc_cal_qual.sv]
module acc_cal_qual (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Qualified calibrate level and command
  input  wire logic calLevel,
  output logic      cmdPulse
);

  logic [acc_pkg::CMD_CNT_W-1:0] lowCntFf;
  logic [acc_pkg::CMD_CNT_W-1:0] highCntFf;
  logic                          cmdFf;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lowCntFf  <= '0;
      highCntFf <= '0;
    end
    else if (!calLevel)
    begin
      highCntFf <= '0;
      if (highCntFf != '0)
        lowCntFf <= {{(acc_pkg::CMD_CNT_W-1){1'b0}}, 1'b1};
      else if (lowCntFf != acc_pkg::CMD_MIN_CYCLES)
        lowCntFf <= lowCntFf + 1'b1;
    end
    else if (highCntFf != acc_pkg::CMD_MIN_CYCLES)
      highCntFf <= highCntFf + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      cmdFf <= 1'b0;
    else
      cmdFf <= calLevel && lowCntFf == acc_pkg::CMD_MIN_CYCLES
               && highCntFf == acc_pkg::CMD_MIN_CYCLES - 4'h1;
  end

  assign cmdPulse = cmdFf;

  cmd_window_a: assert property (@(posedge clk) disable iff (rst)
    cmdFf |-> $past(calLevel, 1) && $past(calLevel, 10) && !$past(calLevel, 11) && !$past(calLevel, 20))
    else $error("calibrate command without full low and high periods");

  count_restart_a: assert property (@(posedge clk) disable iff (rst)
    (calLevel && !$past(calLevel)) |=> highCntFf == 4'h1)
    else $error("high count did not restart on rising level");

endmodule

// [acc_top.sv]
module acc_top #(
  parameter logic [acc_pkg::DLY_W-1:0] DLY_SHORT = acc_pkg::PWRUP_DLY_SHORT,
  parameter logic [acc_pkg::DLY_W-1:0] DLY_LONG  = acc_pkg::PWRUP_DLY_LONG,
  parameter logic [acc_pkg::CAL_W-1:0] CAL_LEN   = acc_pkg::CAL_CYCLES
) (
  // System clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Sample clock
  input  wire logic                       sampleClk,
  // Control pins
  input  wire logic                       calibrate,
  input  wire logic                       powerDownInput,
  input  wire logic                       calDelaySelect,
  input  wire logic                       fullScaleSelect,
  input  wire logic                       outputEdgeSelect,
  // Raw converter word, signed, offset binary scale
  input  wire logic [acc_pkg::RAW_W-1:0]  convRaw,
  // Sample buses, sample clock domain
  output logic      [acc_pkg::CODE_W-1:0] directSampleBus,
  output logic      [acc_pkg::CODE_W-1:0] delayedSampleBus,
  output logic                            directOutOfRange,
  output logic                            delayedOutOfRange,
  output logic                            outputDataClock,
  output logic                            sampleBusOe,
  output logic                            wordsFlushed,
  output logic                            calRunning,
  // Status, system clock domain
  output logic                            calRunningSys,
  output logic                            recalNeededSys
);

  // Sample domain reset, carried over from the system clock
  logic rstS1Ff;
  logic rstS2Ff;
  logic rstS3Ff;
  logic sRstFf;
  logic sRst;

  always_ff @(posedge sampleClk)
  begin
    rstS1Ff <= sys_rst;
    rstS2Ff <= rstS1Ff;
    rstS3Ff <= rstS2Ff;
    if (rstS2Ff == rstS3Ff)
      sRstFf <= rstS2Ff;
  end

  assign sRst = sRstFf;

  // Pin synchronisers
  logic [acc_pkg::PIN_W-1:0] pinRaw;
  logic [acc_pkg::PIN_W-1:0] pinS;
  logic                      calS;
  logic                      pdS;
  logic                      dlySelS;
  logic                      fsrS;
  logic                      edgeS;

  assign pinRaw[acc_pkg::PIN_CAL]  = calibrate;
  assign pinRaw[acc_pkg::PIN_PD]   = powerDownInput;
  assign pinRaw[acc_pkg::PIN_DLY]  = calDelaySelect;
  assign pinRaw[acc_pkg::PIN_FSR]  = fullScaleSelect;
  assign pinRaw[acc_pkg::PIN_EDGE] = outputEdgeSelect;

  acc_sync #(
    .WIDTH (acc_pkg::PIN_W)
  ) pinSync (
    .clk  (sampleClk),
    .rst  (sRst),
    .din  (pinRaw),
    .dout (pinS)
  );

  assign calS    = pinS[acc_pkg::PIN_CAL];
  assign pdS     = pinS[acc_pkg::PIN_PD];
  assign dlySelS = pinS[acc_pkg::PIN_DLY];
  assign fsrS    = pinS[acc_pkg::PIN_FSR];
  assign edgeS   = pinS[acc_pkg::PIN_EDGE];

  // Calibrate command qualifier
  logic cmdPulse;

  acc_cal_qual calQual (
    .clk      (sampleClk),
    .rst      (sRst),
    .calLevel (calS),
    .cmdPulse (cmdPulse)
  );

  // Calibration sequencer
  acc_pkg::acc_state_t         stateFf;
  acc_pkg::acc_state_t         nxtState;
  logic [acc_pkg::DLY_W-1:0]   dlyCntFf;
  logic [acc_pkg::DLY_W-1:0]   dlyTarget;
  logic [acc_pkg::CAL_W-1:0]   calCntFf;
  logic                        strapTakenFf;
  logic                        suppressFf;
  logic                        calRunningFf;
  logic                        startCal;
  logic                        pdState;

  assign dlyTarget = dlySelS ? DLY_LONG : DLY_SHORT;
  assign pdState   = pdS && stateFf != acc_pkg::ST_CAL;

  always_ff @(posedge sampleClk)
  begin
    if (sRst)
    begin
      strapTakenFf <= 1'b0;
      suppressFf   <= 1'b0;
    end
    else if (!strapTakenFf)
    begin
      strapTakenFf <= 1'b1;
      suppressFf   <= calS;
    end
  end

  always_comb
  begin
    nxtState = stateFf;
    startCal = 1'b0;
    unique case (stateFf)
      acc_pkg::ST_WAIT:
      begin
        if (strapTakenFf && !pdS
            && (cmdPulse || (!suppressFf && dlyCntFf >= dlyTarget - 31'h1)))
        begin
          nxtState = acc_pkg::ST_CAL;
          startCal = 1'b1;
        end
      end
      acc_pkg::ST_CAL:
      begin
        if (calCntFf == CAL_LEN - 16'h1)
          nxtState = acc_pkg::ST_IDLE;
      end
      acc_pkg::ST_IDLE:
      begin
        if (!pdS && cmdPulse)
        begin
          nxtState = acc_pkg::ST_CAL;
          startCal = 1'b1;
        end
      end
      default:
      begin
        nxtState = acc_pkg::ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge sampleClk)
  begin
    if (sRst)
      stateFf <= acc_pkg::ST_WAIT;
    else
      stateFf <= nxtState;
  end

  always_ff @(posedge sampleClk)
  begin
    if (sRst)
      dlyCntFf <= '0;
    else if (stateFf == acc_pkg::ST_WAIT && !pdS && dlyCntFf < dlyTarget)
      dlyCntFf <= dlyCntFf + 31'h1;
  end

  always_ff @(posedge sampleClk)
  begin
    if (sRst || stateFf != acc_pkg::ST_CAL)
      calCntFf <= '0;
    else
      calCntFf <= calCntFf + 16'h1;
  end

  always_ff @(posedge sampleClk)
  begin
    if (sRst)
      calRunningFf <= 1'b0;
    else
      calRunningFf <= nxtState == acc_pkg::ST_CAL;
  end

  // Full-scale change since last calibration; a change beats the clear
  logic fsrPrevFf;
  logic recalNeededFf;

  always_ff @(posedge sampleClk)
  begin
    if (sRst)
    begin
      fsrPrevFf     <= fsrS;
      recalNeededFf <= 1'b0;
    end
    else
    begin
      fsrPrevFf     <= fsrS;
      recalNeededFf <= (fsrS != fsrPrevFf) || (recalNeededFf && !startCal);
    end
  end

  // Conversion pipeline: raw word caught on the falling edge
  logic [acc_pkg::RAW_W-1:0]  capRawFf;
  logic [acc_pkg::CODE_W-1:0] pipeCode [acc_pkg::PIPE_DEPTH];
  logic                       pipeOr   [acc_pkg::PIPE_DEPTH];

  always_ff @(negedge sampleClk)
  begin
    if (sRst)
      capRawFf <= '0;
    else
      capRawFf <= convRaw;
  end

  // code passes through as offset binary
  always_ff @(posedge sampleClk)
  begin
    if (sRst)
    begin
      pipeCode[0] <= '0;
      pipeOr[0]   <= 1'b0;
    end
    else
      {pipeOr[0], pipeCode[0]} <= acc_pkg::sat_code(capRawFf);
  end

  // one word per cycle, always moving
  for (genvar i = 1; i < acc_pkg::PIPE_DEPTH; i++)
  begin : gStage
    always_ff @(posedge sampleClk)
    begin
      if (sRst)
      begin
        pipeCode[i] <= '0;
        pipeOr[i]   <= 1'b0;
      end
      else
      begin
        pipeCode[i] <= pipeCode[i-1];
        pipeOr[i]   <= pipeOr[i-1];
      end
    end
  end

  // Demultiplexed output buses and forwarded clock
  logic                       dataClkFf;
  logic                       updNow;
  logic [acc_pkg::CODE_W-1:0] directBusFf;
  logic [acc_pkg::CODE_W-1:0] delayedBusFf;
  logic                       directOrFf;
  logic                       delayedOrFf;

  // update on the selected clock edge
  assign updNow = dataClkFf ^ edgeS;

  always_ff @(posedge sampleClk)
  begin
    if (sRst)
      dataClkFf <= 1'b0;
    else
      dataClkFf <= ~dataClkFf;
  end

  always_ff @(posedge sampleClk)
  begin
    if (sRst)
    begin
      directBusFf  <= '0;
      delayedBusFf <= '0;
      directOrFf   <= 1'b0;
      delayedOrFf  <= 1'b0;
    end
    else if (updNow)
    begin
      directBusFf  <= pipeCode[acc_pkg::DIRECT_TAP];
      delayedBusFf <= pipeCode[acc_pkg::DELAYED_TAP];
      directOrFf   <= pipeOr[acc_pkg::DIRECT_TAP];
      delayedOrFf  <= pipeOr[acc_pkg::DELAYED_TAP];
    end
  end

  // Drivers off in power-down except during calibration; words distrusted until pipeline refilled
  logic                        busOeFf;
  logic [acc_pkg::FLUSH_W-1:0] flushCntFf;
  logic                        flushedFf;

  always_ff @(posedge sampleClk)
  begin
    if (sRst || pdState)
    begin
      busOeFf    <= 1'b0;
      flushCntFf <= '0;
      flushedFf  <= 1'b0;
    end
    else
    begin
      busOeFf <= 1'b1;
      if (flushCntFf != acc_pkg::FLUSH_CYCLES)
        flushCntFf <= flushCntFf + 4'h1;
      else
        flushedFf <= 1'b1;
    end
  end

  // Status into the system clock domain
  logic [1:0] sysStat;

  acc_sync #(
    .WIDTH (2)
  ) sysSync (
    .clk  (clk),
    .rst  (sys_rst),
    .din  ({calRunningFf, recalNeededFf}),
    .dout (sysStat)
  );

  assign calRunningSys     = sysStat[1];
  assign recalNeededSys    = sysStat[0];
  assign directSampleBus   = directBusFf;
  assign delayedSampleBus  = delayedBusFf;
  assign directOutOfRange  = directOrFf;
  assign delayedOutOfRange = delayedOrFf;
  assign outputDataClock   = dataClkFf;
  assign sampleBusOe       = busOeFf;
  assign wordsFlushed      = flushedFf;
  assign calRunning        = calRunningFf;

  sat_low_a: assert property (@(posedge sampleClk) disable iff (sRst)
    capRawFf[acc_pkg::RAW_W-1] |=> pipeCode[0] == acc_pkg::CODE_MIN && pipeOr[0])
    else $error("negative input not clamped to zero code");

  range_flag_a: assert property (@(posedge sampleClk) disable iff (sRst)
    pipeOr[0] == ($past(capRawFf[acc_pkg::RAW_W-1:acc_pkg::CODE_W]) != 2'h0)
    && (!$past(capRawFf[acc_pkg::RAW_W-2]) || $past(capRawFf[acc_pkg::RAW_W-1])
        || pipeCode[0] == acc_pkg::CODE_MAX))
    else $error("high input not clamped or not flagged");

  direct_lat_a: assert property (@(posedge sampleClk) disable iff (sRst)
    $past(updNow) |-> directBusFf == $past(pipeCode[0], 6) && directOrFf == $past(pipeOr[0], 6))
    else $error("direct bus latency wrong");

  pair_order_a: assert property (@(posedge sampleClk) disable iff (sRst)
    $past(updNow) |-> delayedBusFf == $past(pipeCode[0], 7) && delayedOrFf == $past(pipeOr[0], 7))
    else $error("delayed bus does not hold the older sample");

  edge_select_a: assert property (@(posedge sampleClk) disable iff (sRst)
    updNow |=> dataClkFf == $past(edgeS))
    else $error("words changed on the wrong data clock edge");

  cal_length_a: assert property (@(posedge sampleClk) disable iff (sRst)
    $fell(calRunningFf) |-> $past(calCntFf) == CAL_LEN - 16'h1)
    else $error("calibration length wrong");

  pd_ignore_a: assert property (@(posedge sampleClk) disable iff (sRst)
    (pdS && !calRunningFf) |=> !calRunningFf)
    else $error("calibration started while powered down");

  pwrup_delay_a: assert property (@(posedge sampleClk) disable iff (sRst)
    (stateFf == acc_pkg::ST_WAIT && nxtState == acc_pkg::ST_CAL && !cmdPulse)
      |-> dlyCntFf >= dlyTarget - 31'h1 && !suppressFf)
    else $error("power-up calibration before delay elapsed");

  pd_outputs_a: assert property (@(posedge sampleClk) disable iff (sRst)
    pdState |=> !busOeFf && !flushedFf)
    else $error("outputs enabled in power-down");

endmodule

// [acc_rx_model.sv]
module acc_rx_model (
  // Forwarded clock and selects
  input  wire logic                         sampleClk,
  input  wire logic                         outputDataClock,
  input  wire logic                         outputEdgeSelect,
  input  wire logic                         sampleBusOe,
  // Sample buses
  input  wire logic [acc_pkg::CODE_W-1:0]   directSampleBus,
  input  wire logic [acc_pkg::CODE_W-1:0]   delayedSampleBus,
  input  wire logic                         directOutOfRange,
  input  wire logic                         delayedOutOfRange,
  // Rebuilt pair, older word first
  output logic      [acc_pkg::CODE_W:0]     olderWord,
  output logic      [acc_pkg::CODE_W:0]     newerWord,
  output int                                pairs
);
  timeunit 1ns;
  timeprecision 100ps;

  logic prevClk = 1'b0;
  logic selPrev = 1'b0;
  int   selStable = 0;

  initial pairs = 0;

  // Looked at after the edge has settled, as a real capture flop would
  always @(posedge sampleClk)
  begin
    #1;
    // Sender sees a new edge select only after its synchroniser
    if (outputEdgeSelect !== selPrev)
      selStable = 0;
    else if (selStable < 8)
      selStable = selStable + 1;
    selPrev = outputEdgeSelect;
    if (sampleBusOe === 1'b1 && selStable >= 5 && outputDataClock !== prevClk
        && outputDataClock === outputEdgeSelect)
    begin
      olderWord = {delayedOutOfRange, delayedSampleBus};
      newerWord = {directOutOfRange, directSampleBus};
      pairs = pairs + 1;
    end
    prevClk = outputDataClock;
  end
endmodule

// [acc_top_bench.sv]
module acc_top_bench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [30:0] DLY_S = 31'h20;
  localparam logic [30:0] DLY_L = 31'h40;
  localparam logic [15:0] CAL_L = 16'h20;

  typedef struct packed {
    logic [9:0] raw;
    logic [8:0] exp;
  } acc_row_t;

  // Raw word beside flag and code expected
  acc_row_t rows [8] = '{'{10'h3ff, 9'h100}, '{10'h200, 9'h100}, '{10'h000, 9'h000},
    '{10'h07f, 9'h07f}, '{10'h080, 9'h080}, '{10'h0ff, 9'h0ff}, '{10'h100, 9'h1ff}, '{10'h1ff, 9'h1ff}};

  logic       clk = 1'b0;
  logic       sampleClk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       calibrate = 1'b0;
  logic       powerDownInput = 1'b0;
  logic       calDelaySelect = 1'b0;
  logic       fullScaleSelect = 1'b0;
  logic       outputEdgeSelect = 1'b1;
  logic [9:0] convRaw = 10'h000;
  logic [8:0] curExp = 9'h000;
  logic [7:0] directSampleBus;
  logic [7:0] delayedSampleBus;
  logic       directOutOfRange;
  logic       delayedOutOfRange;
  logic       outputDataClock;
  logic       sampleBusOe;
  logic       wordsFlushed;
  logic       calRunning;
  logic       calRunningSys;
  logic       recalNeededSys;
  logic [8:0] olderWord;
  logic [8:0] newerWord;
  logic [8:0] expQ [$];
  int         pairs;
  int         p0;
  int         n_fail = 0;
  int         comparisons = 0;

  always #5 clk = ~clk;
  always #6 sampleClk = ~sampleClk;

  acc_top #(.DLY_SHORT(DLY_S), .DLY_LONG(DLY_L), .CAL_LEN(CAL_L)) i_dut (
    .clk, .sys_rst, .sampleClk, .calibrate, .powerDownInput, .calDelaySelect,
    .fullScaleSelect, .outputEdgeSelect, .convRaw, .directSampleBus, .delayedSampleBus,
    .directOutOfRange, .delayedOutOfRange, .outputDataClock, .sampleBusOe, .wordsFlushed,
    .calRunning, .calRunningSys, .recalNeededSys);

  acc_rx_model i_rx (
    .sampleClk, .outputDataClock, .outputEdgeSelect, .sampleBusOe, .directSampleBus,
    .delayedSampleBus, .directOutOfRange, .delayedOutOfRange, .olderWord, .newerWord, .pairs);

  task automatic check_bit(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic check_word(input logic [8:0] got, input logic [8:0] exp, input string msg);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Expected word of every captured sample, in capture order
  always @(negedge sampleClk)
    expQ.push_back(curExp);

  always @(pairs)
    if (wordsFlushed === 1'b1 && expQ.size() > 8)
    begin
      check_word(newerWord, expQ[expQ.size()-7], "direct word");
      check_word(olderWord, expQ[expQ.size()-8], "delayed word");
    end

  task automatic do_reset(input logic cal, input logic pd, input logic dly);
    @(negedge clk);
    sys_rst = 1'b1;
    calibrate = cal;
    powerDownInput = pd;
    calDelaySelect = dly;
    repeat (16) @(negedge clk);
    check_bit(calRunning, 1'b0, "running in reset");
    check_bit(wordsFlushed, 1'b0, "flushed in reset");
    sys_rst = 1'b0;
  endtask

  // Bounded wait for a calibration, then its length
  task automatic wait_cal(input int lo, input int hi, input string msg);
    int n;
    n = 0;
    while (calRunning !== 1'b1 && n < hi)
    begin
      @(posedge sampleClk);
      #1;
      n++;
    end
    check_bit(n >= lo && n < hi, 1'b1, msg);
    n = 0;
    while (calRunning === 1'b1 && n < 100)
    begin
      @(posedge sampleClk);
      #1;
      n++;
    end
    check_word(9'(n), 9'(CAL_L), "running length");
  endtask

  task automatic no_cal(input int cycles, input string msg);
    logic seen;
    seen = 1'b0;
    repeat (cycles)
    begin
      @(posedge sampleClk);
      #1;
      seen = seen | (calRunning !== 1'b0);
    end
    check_bit(seen, 1'b0, msg);
  endtask

  task automatic cal_pin(input int lowN, input int highN);
    @(negedge clk) calibrate = 1'b0;
    repeat (lowN) @(posedge sampleClk);
    @(negedge clk) calibrate = 1'b1;
    repeat (highN) @(posedge sampleClk);
  endtask

  initial
  begin
    #300000;
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end

  initial
  begin
    do_reset(1'b0, 1'b0, 1'b0);
    wait_cal(31, 45, "power-up short");
    for (int e = 0; e < 2; e++)
    begin
      @(negedge clk) outputEdgeSelect = e[0];
      for (int i = 0; i < 8; i++)
      begin
        @(posedge sampleClk);
        convRaw <= rows[i].raw;
        curExp <= rows[i].exp;
      end
      p0 = pairs;
      repeat (12) @(posedge sampleClk);
      check_word(9'(pairs - p0), 9'h006, "pair rate");
    end
    do_reset(1'b0, 1'b0, 1'b1);
    wait_cal(63, 77, "power-up long");
    // commands only once power-up has settled
    cal_pin(12, 0);
    wait_cal(11, 22, "command");
    no_cal(40, "no repeat while high");
    cal_pin(7, 30);
    no_cal(20, "short low");
    cal_pin(12, 7);
    @(negedge clk) calibrate = 1'b0;
    no_cal(40, "short high");
    @(negedge clk) fullScaleSelect = 1'b1;
    repeat (20) @(negedge clk);
    check_bit(recalNeededSys, 1'b1, "recal needed");
    cal_pin(12, 0);
    fork
      wait_cal(11, 22, "command with power-down");
      begin
        repeat (24) @(posedge sampleClk);
        @(negedge clk) powerDownInput = 1'b1;
      end
    join
    repeat (8) @(posedge sampleClk);
    #1;
    check_bit(sampleBusOe, 1'b0, "outputs off");
    check_bit(recalNeededSys, 1'b0, "recal cleared");
    check_bit(calRunningSys, 1'b0, "running sys low");
    cal_pin(12, 20);
    no_cal(30, "command in power-down");
    @(negedge clk) calibrate = 1'b0;
    @(negedge clk) powerDownInput = 1'b0;
    no_cal(30, "ignored command");
    check_bit(sampleBusOe, 1'b1, "outputs on");
    check_bit(wordsFlushed, 1'b1, "flushed");
    do_reset(1'b1, 1'b0, 1'b0);
    no_cal(60, "strap high");
    cal_pin(12, 0);
    wait_cal(11, 22, "strap then command");
    do_reset(1'b0, 1'b1, 1'b0);
    no_cal(80, "power-down at power-up");
    check_bit(sampleBusOe, 1'b0, "outputs off at power-up");
    @(negedge clk) powerDownInput = 1'b0;
    wait_cal(31, 45, "delay after wake");
    test_done();
  end
endmodule
